// *** i2c_line_if.sv ***
// Carrier between line sampler, shift register and port core.
// Assumes all three run on one clock.
`timescale 1ns/100ps
`default_nettype none
interface i2c_line_if;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sh_in;
   logic sh_out;
   logic sh_ld;
   logic sh_bit;
   logic [7:0] ld_data;
   logic [7:0] sr;

   modport sampler (output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
   modport shifter (input sh_in, sh_out, sh_ld, sh_bit, ld_data, output sr);
   modport core (input scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, sr,
                 output sh_in, sh_out, sh_ld, sh_bit, ld_data);
endinterface
`default_nettype wire

// *** i2c_line_sampler.sv ***
// Synchroniser and edge, start and stop detection for the bus pins.
// Assumes raw pin levels, asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module i2c_line_sampler (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Raw pins
   input wire logic scl_i,
   input wire logic sda_i,
   // Line events
   i2c_line_if.sampler line
);
   import i2c_slave_pkg::*;

   sampler_regs_t r;
   sampler_regs_t next_r;

   // ****************************************
   // Two-stage sync and history
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.scl_m = scl_i;
      next_r.scl_s = r.scl_m;
      next_r.scl_d = r.scl_s;
      next_r.sda_m = sda_i;
      next_r.sda_s = r.sda_m;
      next_r.sda_d = r.sda_s;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '1;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   // ****************************************
   // Events
   // ****************************************
   assign line.scl_s = r.scl_s;
   assign line.sda_s = r.sda_s;
   assign line.scl_rise = r.scl_s & ~r.scl_d;
   assign line.scl_fall = ~r.scl_s & r.scl_d;
   assign line.start_det = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
   assign line.stop_det = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
endmodule
`default_nettype wire

// *** i2c_master_model.sv ***
// Behavioural bus master, 160 ns bit period.
// Assumes pull-ups on the wire; waits while the slave holds the clock.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
   // Wire levels
   input wire logic scl_i,
   input wire logic sda_i,
   // Pulls, high pulls low
   output logic scl_oe_o,
   output logic sda_oe_o
);
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   // One bit, sampled while clock high
   task automatic bit_x(input logic b, output logic r);
      sda_oe_o = !b;
      #70;
      scl_oe_o = 1'b0;
      #1;
      for (int n = 0; n < 5000 && !scl_i; n++) #20;
      #19;
      r = sda_i;
      #20;
      scl_oe_o = 1'b1;
      #50;
   endtask
   task automatic start_c();
      #3;
      sda_oe_o = 1'b0;
      #50;
      scl_oe_o = 1'b0;
      #60;
      sda_oe_o = 1'b1;
      #50;
      scl_oe_o = 1'b1;
      #50;
   endtask
   task automatic stop_c();
      sda_oe_o = 1'b1;
      #50;
      scl_oe_o = 1'b0;
      #60;
      sda_oe_o = 1'b0;
      #50;
   endtask
   task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
                       output logic s_ack);
      #3;
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(m_ack, s_ack);
   endtask
endmodule
`default_nettype wire

// *** i2c_shift_reg.sv ***
// Eight-bit shift register: serial in, serial out, parallel load.
// Assumes at most one operation per cycle; load wins.
`timescale 1ns/100ps
`default_nettype none
module i2c_shift_reg (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Shift control
   i2c_line_if.shifter line
);
   import i2c_slave_pkg::*;

   shifter_regs_t r;
   shifter_regs_t next_r;

   always_comb begin
      next_r = r;
      if (line.sh_ld) begin
         next_r.sr = line.ld_data;
      end else if (line.sh_in) begin
         next_r.sr = {r.sr[6:0], line.sh_bit};
      end else if (line.sh_out) begin
         next_r.sr = {r.sr[6:0], 1'b1};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign line.sr = r.sr;
endmodule
`default_nettype wire

// *** i2c_slave_pkg.sv ***
// Types shared by the serial port modules.
// Assumes the constants header is compiled alongside.
`default_nettype none
package i2c_slave_pkg;
   typedef logic [7:0] byte_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_RX = 2'b10,
      ST_TX = 2'b11
   } core_state_t;

   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_d;
      logic sda_m;
      logic sda_s;
      logic sda_d;
   } sampler_regs_t;

   typedef struct packed {
      byte_t sr;
   } shifter_regs_t;

   typedef struct packed {
      core_state_t state;
      logic [3:0] cnt;
      byte_t rx_buf;
      byte_t addr;
      logic en;
      logic [3:0] mode;
      logic clock_release_bit;
      logic ov;
      logic bf;
      logic irq;
      logic ua;
      logic rw;
      logic da;
      logic st;
      logic sp;
      logic hi_ok;
      logic addr_done;
      logic go_tx;
      logic ua_pend;
      logic data_byte;
      logic nack;
      logic sda_low;
      logic scl_low;
   } core_regs_t;
endpackage
`default_nettype wire

// *** i2c_slave_port.sv ***
// I2C slave port core: addressing, acknowledge, buffer and stretching.
// Assumes an external master on open-drain SCL/SDA with pull-ups.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_slave_regs.svh"
module i2c_slave_port (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Bus pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // First control register
   input wire logic ctrl1_wr_i,
   input wire i2c_slave_pkg::byte_t ctrl1_wdata_i,
   output i2c_slave_pkg::byte_t ctrl1_o,
   // Second control register
   input wire i2c_slave_pkg::byte_t ctrl2_i,
   // Slave address register
   input wire logic addr_wr_i,
   input wire i2c_slave_pkg::byte_t addr_wdata_i,
   output i2c_slave_pkg::byte_t addr_o,
   // Receive/transmit buffer
   input wire logic buf_rd_i,
   input wire logic buf_wr_i,
   input wire i2c_slave_pkg::byte_t buf_wdata_i,
   output i2c_slave_pkg::byte_t buf_o,
   // Status and interrupt flag
   output i2c_slave_pkg::byte_t status_o,
   input wire logic irq_clr_i,
   output logic irq_o
);
   import i2c_slave_pkg::*;

   core_regs_t r;
   core_regs_t next_r;
   i2c_line_if line ();

   logic slave_on;
   logic tenbit;
   logic sp_irq;
   logic stretch_en;
   logic addr_hit;
   logic hi_hit;
   logic rx_ok;

   // ****************************************
   // Submodules
   // ****************************************
   i2c_line_sampler u_sampler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .line(line)
   );

   i2c_shift_reg u_shift (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .line(line)
   );

   // ****************************************
   // Mode decode
   // ****************************************
   // mode selection
   always_comb begin
      case (r.mode)
         `MODE_SLV7: begin
            tenbit = 1'b0;
            sp_irq = 1'b0;
         end
         `MODE_SLV10: begin
            tenbit = 1'b1;
            sp_irq = 1'b0;
         end
         `MODE_SLV7_SP: begin
            tenbit = 1'b0;
            sp_irq = 1'b1;
         end
         `MODE_SLV10_SP: begin
            tenbit = 1'b1;
            sp_irq = 1'b1;
         end
         default: begin
            tenbit = 1'b0;
            sp_irq = 1'b0;
         end
      endcase
   end

   assign slave_on = r.en & ((r.mode == `MODE_SLV7) | (r.mode == `MODE_SLV10) |
                             (r.mode == `MODE_SLV7_SP) | (r.mode == `MODE_SLV10_SP));
   assign stretch_en = ctrl2_i[`SC_STRETCH_BIT];
   assign hi_hit = (line.sr[7:1] == r.addr[7:1]) &
                   (~tenbit | (line.sr[7:3] == `ADDR10_PREFIX));
   assign addr_hit = (tenbit & r.hi_ok) ? (line.sr == r.addr) : hi_hit;
   assign rx_ok = ~r.bf & ~r.ov;

   // ****************************************
   // Shift register control
   // ****************************************
   // sample on rising edge
   assign line.sh_in = line.scl_rise & ((r.state == ST_ADDR) | (r.state == ST_RX)) &
                       (r.cnt < `BYTE_BITS);
   assign line.sh_bit = line.sda_s;
   assign line.sh_out = line.scl_fall & (r.state == ST_TX) & (r.cnt < `BYTE_BITS);
   assign line.sh_ld = slave_on & buf_wr_i;
   assign line.ld_data = buf_wdata_i;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_r = r;
      // Software writes
      if (ctrl1_wr_i) begin
         next_r.en = ctrl1_wdata_i[`FC_EN_BIT];
         next_r.mode = ctrl1_wdata_i[`FC_MODE_MSB:`FC_MODE_LSB];
         next_r.clock_release_bit = ctrl1_wdata_i[`FC_CKP_BIT];
         next_r.ov = ctrl1_wdata_i[`FC_OV_BIT];
      end
      if (addr_wr_i) begin
         next_r.addr = addr_wdata_i;
         next_r.ua = 1'b0;
      end
      if (buf_rd_i) begin
         next_r.bf = 1'b0;
      end
      if (irq_clr_i) begin
         next_r.irq = 1'b0;
      end
      if (line.sh_ld) begin
         next_r.bf = 1'b1;
      end

      if (!slave_on) begin
         next_r.state = ST_IDLE;
         next_r.cnt = 4'h0;
         next_r.st = 1'b0;
         next_r.sp = 1'b0;
         next_r.rw = 1'b0;
         next_r.ua = 1'b0;
         next_r.da = 1'b0;
         next_r.hi_ok = 1'b0;
         next_r.addr_done = 1'b0;
         next_r.sda_low = 1'b0;
      end else if (line.start_det) begin
         next_r.state = ST_ADDR;
         next_r.cnt = 4'h0;
         next_r.st = 1'b1;
         next_r.sp = 1'b0;
         next_r.hi_ok = 1'b0;
         next_r.sda_low = 1'b0;
         if (sp_irq) begin
            next_r.irq = 1'b1;
         end
      end else if (line.stop_det) begin
         next_r.state = ST_IDLE;
         next_r.cnt = 4'h0;
         next_r.sp = 1'b1;
         next_r.st = 1'b0;
         next_r.addr_done = 1'b0;
         next_r.sda_low = 1'b0;
         if (sp_irq) begin
            next_r.irq = 1'b1;
         end
      end else begin
         case (r.state)
            ST_ADDR, ST_RX: begin
               if (line.scl_rise && r.cnt < `BYTE_BITS) begin
                  next_r.cnt = r.cnt + 4'h1;
               end else if (line.scl_fall && r.cnt == `BYTE_BITS) begin
                  next_r.cnt = `ACK_SLOT;
                  next_r.data_byte = (r.state == ST_RX);
                  next_r.go_tx = 1'b0;
                  next_r.ua_pend = 1'b0;
                  if (r.state == ST_ADDR && !addr_hit) begin
                     next_r.state = ST_IDLE;
                  end else begin
                     if (rx_ok) begin
                        next_r.rx_buf = line.sr;
                        next_r.bf = 1'b1;
                        next_r.sda_low = 1'b1;
                     end else if (r.bf) begin
                        next_r.ov = 1'b1;
                     end
                     next_r.da = (r.state == ST_RX);
                     if (r.state == ST_ADDR) begin
                        if (!tenbit || !r.hi_ok) begin
                           next_r.rw = line.sr[0];
                        end
                        if (!tenbit) begin
                           next_r.go_tx = line.sr[0];
                        end else if (r.hi_ok) begin
                           next_r.ua_pend = 1'b1;
                           next_r.addr_done = 1'b1;
                        end else if (line.sr[0] && r.addr_done) begin
                           next_r.go_tx = 1'b1;
                        end else begin
                           next_r.ua_pend = 1'b1;
                           next_r.hi_ok = 1'b1;
                        end
                     end
                  end
               end else if (line.scl_fall && r.cnt == `ACK_SLOT) begin
                  next_r.irq = 1'b1;
                  next_r.sda_low = 1'b0;
                  next_r.cnt = 4'h0;
                  if (r.go_tx) begin
                     next_r.state = ST_TX;
                     next_r.clock_release_bit = 1'b0;
                  end else if (r.ua_pend) begin
                     next_r.ua = 1'b1;
                     next_r.state = (r.hi_ok && !r.addr_done) ? ST_ADDR : ST_RX;
                  end else begin
                     next_r.state = ST_RX;
                     if (stretch_en && r.bf && !buf_rd_i && (r.data_byte || !tenbit)) begin
                        next_r.clock_release_bit = 1'b0;
                     end
                  end
               end
            end
            ST_TX: begin
               if (line.scl_fall && r.cnt < `BYTE_BITS) begin
                  next_r.cnt = r.cnt + 4'h1;
                  if (r.cnt == `BYTE_BITS - 4'h1) begin
                     next_r.bf = line.sh_ld;
                  end
               end else if (line.scl_rise && r.cnt == `BYTE_BITS) begin
                  next_r.nack = line.sda_s;
               end else if (line.scl_fall && r.cnt == `BYTE_BITS) begin
                  next_r.irq = 1'b1;
                  next_r.cnt = 4'h0;
                  next_r.da = 1'b1;
                  if (r.nack) begin
                     next_r.state = ST_IDLE;
                     next_r.rw = 1'b0;
                     next_r.da = 1'b0;
                     next_r.ua = 1'b0;
                     next_r.st = 1'b0;
                     next_r.sp = 1'b0;
                  end else begin
                     next_r.clock_release_bit = 1'b0;
                  end
               end
            end
            default: begin
               next_r.cnt = 4'h0;
            end
         endcase
      end

      if (ctrl1_wr_i && ctrl1_wdata_i[`FC_CKP_BIT]) begin
         next_r.clock_release_bit = 1'b1;
      end
      // hold only once line is low
      next_r.scl_low = slave_on & (~next_r.clock_release_bit | next_r.ua) & (r.scl_low | ~line.scl_s);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.state <= ST_IDLE;
         r.addr <= `ADDR_RESET;
         r.rx_buf <= `BUF_RESET;
         r.en <= 1'(`FC_RESET >> `FC_EN_BIT);
         r.clock_release_bit <= 1'(`FC_RESET >> `FC_CKP_BIT);
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // open-drain, never driven high
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = r.scl_low;
   assign sda_oe_o = r.sda_low |
                     ((r.state == ST_TX) & (r.cnt < `BYTE_BITS) & ~line.sr[7] & slave_on);

   always_comb begin
      ctrl1_o = '0;
      ctrl1_o[`FC_MODE_MSB:`FC_MODE_LSB] = r.mode;
      ctrl1_o[`FC_CKP_BIT] = r.clock_release_bit;
      ctrl1_o[`FC_EN_BIT] = r.en;
      ctrl1_o[`FC_OV_BIT] = r.ov;
      status_o = '0;
      status_o[`ST_BF_BIT] = r.bf;
      status_o[`ST_UA_BIT] = r.ua;
      status_o[`ST_RW_BIT] = r.rw;
      status_o[`ST_S_BIT] = r.st;
      status_o[`ST_P_BIT] = r.sp;
      status_o[`ST_DA_BIT] = r.da;
   end

   assign addr_o = r.addr;
   assign buf_o = r.rx_buf;
   assign irq_o = r.irq;
endmodule
`default_nettype wire

// *** i2c_slave_port_monitor.sv ***
// Checker of the serial port pins, flags and buffer.
// Assumes binding into i2c_slave_port; one clock, synchronous high reset.
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_port_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pins
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   // Software side
   input wire logic ctrl1_wr_i,
   input wire i2c_slave_pkg::byte_t ctrl1_o,
   input wire logic buf_rd_i,
   input wire logic buf_wr_i,
   input wire i2c_slave_pkg::byte_t buf_o,
   input wire i2c_slave_pkg::byte_t status_o,
   input wire logic irq_clr_i,
   input wire logic irq_o
);
   import i2c_slave_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ****************
   // Properties
   // ****************
   property p_open_drain; !scl_o && !sda_o; endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");
   property p_off_quiet; !ctrl1_o[5] [*3] |-> !scl_oe_o && !sda_oe_o; endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("pin pulled while off");
   property p_release; $rose(ctrl1_o[4]) && !status_o[1] |-> ##[0:2] !scl_oe_o; endproperty
   a_release: assert property (p_release) else $error("clock not released");
   property p_hold; $rose(scl_oe_o) |-> ##[0:1] (!ctrl1_o[4] || status_o[1]); endproperty
   a_hold: assert property (p_hold) else $error("clock held without cause");
   property p_irq_hold; irq_o && !irq_clr_i |=> irq_o; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
   property p_bf_read; buf_rd_i |=> !status_o[0] || sda_oe_o; endproperty
   a_bf_read: assert property (p_bf_read) else $error("full kept after read");
   property p_ov_hold; ctrl1_o[6] && !ctrl1_wr_i |=> ctrl1_o[6]; endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("overflow lost");
   property p_buf_keep; status_o[0] && !buf_rd_i && !buf_wr_i |=> $stable(buf_o); endproperty
   a_buf_keep: assert property (p_buf_keep) else $error("full buffer loaded");
   property p_ack_len; $rose(sda_oe_o) |-> sda_oe_o [*5]; endproperty
   a_ack_len: assert property (p_ack_len) else $error("data low too short");
   property p_ack_irq;
      $fell(sda_oe_o) && !$past(status_o[2]) && ctrl1_o[5] |-> ##[0:2] irq_o;
   endproperty
   a_ack_irq: assert property (p_ack_irq) else $error("no flag at ninth fall");
   c_stretch: cover property ($rose(scl_oe_o));
   c_update: cover property ($rose(status_o[1]));
   c_over: cover property ($rose(ctrl1_o[6]));
endmodule
bind i2c_slave_port i2c_slave_port_monitor u_mon (.clk_i, .rst_i, .scl_o, .scl_oe_o,
   .sda_o, .sda_oe_o, .ctrl1_wr_i, .ctrl1_o, .buf_rd_i, .buf_wr_i, .buf_o, .status_o,
   .irq_clr_i, .irq_o);
`default_nettype wire

// *** i2c_slave_regs.svh ***
// Bit positions, reset values and mode codes of the serial port.
// Assumes inclusion by bare name from the design files.
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

// ****************************************
// First control register
// ****************************************
`define FC_MODE_MSB 3
`define FC_MODE_LSB 0
`define FC_CKP_BIT 4
`define FC_EN_BIT 5
`define FC_OV_BIT 6
`define FC_RESET 8'h00

// ****************************************
// Second control register and status
// ****************************************
`define SC_STRETCH_BIT 0
`define ST_BF_BIT 0
`define ST_UA_BIT 1
`define ST_RW_BIT 2
`define ST_S_BIT 3
`define ST_P_BIT 4
`define ST_DA_BIT 5
`define ADDR_RESET 8'h00
`define BUF_RESET 8'h00

// ****************************************
// Mode codes and counts
// ****************************************
`define MODE_SLV7 4'h6
`define MODE_SLV10 4'h7
`define MODE_SLV7_SP 4'he
`define MODE_SLV10_SP 4'hf
`define ADDR10_PREFIX 5'h1e
`define BYTE_BITS 4'h8
`define ACK_SLOT 4'h9

`endif

// *** tb_top.sv ***
// Self-checking bench of the serial port slave.
// Assumes the design, its checker and the master model compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import i2c_slave_pkg::*;
   typedef struct packed {
      logic en;
      logic [3:0] mode;
      byte_t sent;
      logic ack;
      logic irq;
   } row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic ctrl1_wr_i, addr_wr_i, buf_rd_i, buf_wr_i, irq_clr_i;
   byte_t ctrl1_wdata_i, ctrl2_i, addr_wdata_i, buf_wdata_i, ctrl1_o, addr_o, buf_o;
   byte_t status_o, q;
   logic scl_oe_o, sda_oe_o, irq_o, m_scl, m_sda, a;
   wire logic scl = !(m_scl || scl_oe_o);
   wire logic sda = !(m_sda || sda_oe_o);
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   row_t rows [7] = '{'{1'b1, 4'h6, 8'h52, 1'b0, 1'b1}, '{1'b1, 4'h6, 8'h54, 1'b1, 1'b0},
      '{1'b1, 4'he, 8'h54, 1'b1, 1'b1}, '{1'b0, 4'h6, 8'h52, 1'b1, 1'b0},
      '{1'b1, 4'h8, 8'h52, 1'b1, 1'b0}, '{1'b1, 4'hb, 8'h52, 1'b1, 1'b0},
      '{1'b1, 4'hf, 8'h54, 1'b1, 1'b1}};
   i2c_slave_port u_dut (.clk_i, .rst_i, .ce_i, .scl_i(scl), .scl_o(), .scl_oe_o,
      .sda_i(sda), .sda_o(), .sda_oe_o, .ctrl1_wr_i, .ctrl1_wdata_i, .ctrl1_o, .ctrl2_i,
      .addr_wr_i, .addr_wdata_i, .addr_o, .buf_rd_i, .buf_wr_i, .buf_wdata_i, .buf_o,
      .status_o, .irq_clr_i, .irq_o);
   i2c_master_model u_mst (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
   always #10 clk_i = ~clk_i;
   // ****************
   // Tasks
   // ****************
   // Strobe 0 ctrl1, 1 address, 2 buffer write, 3 buffer read, 4 flag clear
   task automatic sw(input int k, input byte_t d);
      @(negedge clk_i);
      {ctrl1_wr_i, addr_wr_i, buf_wr_i, buf_rd_i, irq_clr_i} = 5'b10000 >> k;
      {ctrl1_wdata_i, addr_wdata_i, buf_wdata_i} = {3{d}};
      @(negedge clk_i);
      {ctrl1_wr_i, addr_wr_i, buf_wr_i, buf_rd_i, irq_clr_i} = '0;
      @(negedge clk_i);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (8) @(negedge clk_i);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         conclude();
      end
   end
   // ****************
   // Sequence
   // ****************
   initial begin
      {ctrl1_wr_i, addr_wr_i, buf_rd_i, buf_wr_i, irq_clr_i} = '0;
      {ctrl1_wdata_i, ctrl2_i, addr_wdata_i, buf_wdata_i} = '0;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      chk({ctrl1_o, addr_o, buf_o, status_o}, 32'h0);
      chk({irq_o, scl_oe_o, sda_oe_o}, 32'h0);
      ce_i = 1'b0;
      sw(0, 8'h36);
      ce_i = 1'b1;
      chk(ctrl1_o, 8'h00);
      sw(1, 8'h52);
      for (int i = 0; i < 7; i++) begin
         sw(0, {2'b00, rows[i].en, 1'b1, rows[i].mode});
         sw(3, 8'h00);
         sw(4, 8'h00);
         u_mst.start_c();
         u_mst.xfer(rows[i].sent, 1'b1, q, a);
         chk(a, rows[i].ack);
         u_mst.stop_c();
         settle();
         chk(irq_o, rows[i].irq);
         if (!rows[i].ack) chk(buf_o, rows[i].sent);
      end
      sw(0, 8'h36);
      sw(3, 8'h00);
      u_mst.start_c();
      u_mst.xfer(8'h52, 1'b1, q, a);
      chk(status_o & 8'h25, 8'h01);
      ctrl2_i = 8'h01;
      sw(3, 8'h00);
      sw(4, 8'h00);
      u_mst.xfer(8'ha5, 1'b1, q, a);
      settle();
      chk({a, irq_o, scl_oe_o, ctrl1_o[4], buf_o}, {4'b0110, 8'ha5});
      sw(0, 8'h36);
      chk(scl_oe_o, 1'b0);
      u_mst.xfer(8'h3c, 1'b1, q, a);
      settle();
      chk({a, irq_o, ctrl1_o[6], buf_o}, {3'b111, 8'ha5});
      sw(0, 8'h76);
      sw(3, 8'h00);
      chk({ctrl1_o[6], status_o[0]}, 2'b10);
      sw(0, 8'h36);
      fork
         u_mst.xfer(8'h81, 1'b1, q, a);
         begin
            #1310;
            sw(3, 8'h00);
         end
      join
      settle();
      chk({a, scl_oe_o, ctrl1_o[4], buf_o}, {3'b001, 8'h81});
      u_mst.stop_c();
      ctrl2_i = 8'h00;
      sw(4, 8'h00);
      u_mst.start_c();
      u_mst.xfer(8'h53, 1'b1, q, a);
      settle();
      chk({a, status_o[2], scl_oe_o, ctrl1_o[4], irq_o}, 5'b01101);
      sw(2, 8'hc9);
      sw(0, 8'h36);
      u_mst.xfer(8'hff, 1'b0, q, a);
      settle();
      chk({q, scl_oe_o, irq_o}, {8'hc9, 2'b11});
      sw(2, 8'h5a);
      sw(0, 8'h36);
      u_mst.xfer(8'hff, 1'b1, q, a);
      settle();
      chk({q, scl_oe_o, status_o[2]}, {8'h5a, 2'b00});
      u_mst.stop_c();
      sw(0, 8'h37);
      sw(1, 8'hf2);
      sw(3, 8'h00);
      sw(4, 8'h00);
      u_mst.start_c();
      u_mst.xfer(8'hf2, 1'b1, q, a);
      settle();
      chk({a, status_o[1:0], scl_oe_o, irq_o}, 5'b01111);
      sw(1, 8'h34);
      chk({status_o[1], scl_oe_o, addr_o}, {2'b00, 8'h34});
      sw(3, 8'h00);
      u_mst.xfer(8'h34, 1'b1, q, a);
      settle();
      chk({a, status_o[1], buf_o}, {2'b01, 8'h34});
      sw(1, 8'hf2);
      sw(3, 8'h00);
      u_mst.start_c();
      u_mst.xfer(8'hf3, 1'b1, q, a);
      settle();
      chk({a, status_o[2:1], scl_oe_o}, 4'b0101);
      sw(2, 8'h81);
      sw(0, 8'h37);
      u_mst.xfer(8'hff, 1'b1, q, a);
      chk(q, 8'h81);
      u_mst.stop_c();
      settle();
      chk(status_o[4:3], 2'b10);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      chk({ctrl1_o, status_o, buf_o, irq_o, scl_oe_o}, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
